/* File: src/dsr_defs.svh */
// dsr_defs.svh - offsets, field positions, reset values and timing counts
// assumes: included by bare name from the deserializer lock-control files
`ifndef DSR_DEFS_SVH
`define DSR_DEFS_SVH

// ========
// register byte addresses
`define DSR_ADDR_CONFIG    5'h00
`define DSR_ADDR_STATUS    5'h04
`define DSR_ADDR_IRQ_STAT  5'h08
`define DSR_ADDR_IRQ_MASK  5'h0c

// ========
// config field positions (same layout as the strap bus)
`define DSR_F_BOOST_EN     0
`define DSR_F_BOOST_LVL    3:1
`define DSR_F_CLK_EDGE     4
`define DSR_F_DATA_EDGE    5
`define DSR_F_SPREAD       9:6
`define DSR_F_LOW_BAND     10
`define DSR_F_IDLE_SEL     11
`define DSR_F_FB_FREQ      14:12
`define DSR_CFG_W          15

// irq bits
`define DSR_IRQ_LOCK       0
`define DSR_IRQ_LOSS       1
`define DSR_IRQ_STOP       2

// ========
// reset values
`define DSR_CFG_RESET      15'h0000
`define DSR_MASK_RESET     3'h0

// ========
// timing
`define DSR_CLK_MHZ        125
`define DSR_STOP_NS        400
`define DSR_STOP_CYC       ((`DSR_STOP_NS * `DSR_CLK_MHZ) / 1000)
`define DSR_LOCK_EDGES     16
`define DSR_OSC_HALF_NS    40
`define DSR_OSC_HALF_CYC   ((`DSR_OSC_HALF_NS * `DSR_CLK_MHZ) / 1000)

// modulation period divisors in link clocks
`define DSR_DIV_HI_0       2168
`define DSR_DIV_HI_1       1300
`define DSR_DIV_HI_2       868
`define DSR_DIV_HI_3       650
`define DSR_DIV_LO_0       620
`define DSR_DIV_LO_1       370
`define DSR_DIV_LO_2       258
`define DSR_DIV_LO_3       192

`endif

/* File: src/dsr_pkg.sv */
// dsr_pkg.sv - types shared by the deserializer lock-control files
// assumes: compiled before every module that imports it
package dsr_pkg;

    // ========
    // link state
    typedef enum logic [1:0] {
        DSR_PWR_DOWN = 2'b00,
        DSR_ACQUIRE  = 2'b01,
        DSR_LOCKED   = 2'b10,
        DSR_SLEEP    = 2'b11
    } dsr_state_t;

endpackage : dsr_pkg

/* File: src/dsr_spread.sv */
// dsr_spread.sv - triangle profile generator for output spread modulation
// assumes: step is a one-cycle pulse per recovered link clock
`timescale 1ns/100ps
`include "dsr_defs.svh"

module dsr_spread import dsr_pkg::*; (
    input  wire logic        clk,
    input  wire logic        sys_rst,
    input  wire logic        step,
    input  wire logic        enable,
    input  wire logic [3:0]  code,
    input  wire logic        low_band,
    output logic             spread_active,
    output logic [1:0]       spread_depth,
    output logic             spread_dir
);

    // ========
    // code decode: code zero is off, codes 1 to 15 fall in four groups, the last holding only three codes
    wire        code_on = enable && (code != 4'h0);
    wire [3:0]  code_m1 = code - 4'h1;
    wire [1:0]  group   = code_m1[3:2];
    wire [11:0] div_hi  = (group == 2'h0) ? 12'(`DSR_DIV_HI_0) :
                          (group == 2'h1) ? 12'(`DSR_DIV_HI_1) :
                          (group == 2'h2) ? 12'(`DSR_DIV_HI_2) : 12'(`DSR_DIV_HI_3);
    wire [11:0] div_lo  = (group == 2'h0) ? 12'(`DSR_DIV_LO_0) :
                          (group == 2'h1) ? 12'(`DSR_DIV_LO_1) :
                          (group == 2'h2) ? 12'(`DSR_DIV_LO_2) : 12'(`DSR_DIV_LO_3);
    wire [11:0] divisor = low_band ? div_lo : div_hi;   // R6 R7
    wire [10:0] half    = divisor[11:1];
    logic [10:0] phase;
    wire        at_turn = step && (phase >= half - 11'h001);

    // ========
    // the ramp direction flips every half modulation period
    always_ff @(posedge clk) begin
        if (sys_rst || !code_on) begin
            phase      <= 11'h000;
            spread_dir <= 1'b0;
        end else if (at_turn) begin
            phase      <= 11'h000;
            spread_dir <= ~spread_dir;
        end else if (step) begin
            phase      <= phase + 11'h001;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            spread_active <= 1'b0;
            spread_depth  <= 2'h0;
        end else begin
            spread_active <= code_on;       // R4
            spread_depth  <= code_m1[1:0];  // R6 R7
        end
    end

endmodule : dsr_spread

/* File: src/dsr_lock_ctrl.sv */
// dsr_lock_ctrl.sv - deserializer output, lock and configuration control
// assumes: link clock, power-down pin, straps and recovered data are
// asynchronous to clk; software uses Avalon-MM with waitrequest
//
// What this block does
// R1 - boost select bit zero low disables equalization
// R2 - upper boost bits pick eight boost steps
// R3 - separate edge-rate selects for clock and data
// R4 - spread modulates clock and data outputs together
// R5 - software must disable spread above 65 MHz
// R6 - high band: code groups use higher divisors
// R7 - low band: code groups use lower divisors
// R8 - power down returns control registers to reset
// R9 - stopped stream sleeps, restart relocks
// R10 - stream stop sleeps, registers are retained
// R11 - leaving power down starts acquisition, lock low
// R12 - completed lock drives lock output high
// R13 - lost clock drops lock, outputs follow idle select; the code keeps lock driven low and pass driven high whatever idle select is
// R14 - clock source changeover holds level, no glitch
// R15 - lost stream with fallback runs oscillator clock
// R16 - power down outputs follow idle select
// R17 - idle select low floats, high drives low; the code drives pass high in power down when idle select is high
// R18 - fallback active: data low, lock low, pass high
// R19 - register values override straps once written
//
// The register addresses and register access over Avalon-MM were left to the implementer.
`timescale 1ns/100ps
`include "dsr_defs.svh"

module dsr_lock_ctrl import dsr_pkg::*; (
    input  wire logic        clk,
    input  wire logic        sys_rst,
    // avalon-mm slave
    input  wire logic [4:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    output logic [31:0]      avs_readdata,
    output logic             avs_waitrequest,
    output logic             irq,
    // link side
    input  wire logic        link_clk,
    input  wire logic        power_down_n,
    input  wire logic [23:0] data_in,
    input  wire logic [2:0]  slow_signal_in,
    input  wire logic [14:0] strap_in,
    // analog controls
    output logic             receiver_boost_enable,
    output logic [2:0]       receiver_boost_level,
    output logic             clock_edge_rate_select,
    output logic             data_edge_rate_select,
    output logic             spread_active,
    output logic [1:0]       spread_depth,
    output logic             spread_dir,
    // parallel outputs, enables low while driving
    output logic             recovered_clock_out,
    output logic             recovered_clock_oe_n,
    output logic [23:0]      data_out,
    output logic [2:0]       slow_signal_out,
    output logic             data_oe_n,
    output logic             lock_out,
    output logic             lock_oe_n,
    output logic             pass_out,
    output logic             pass_oe_n
);

    // ========
    // synchronisers
    logic [1:0]  lclk_sync;
    logic        lclk_d;
    logic [1:0]  pdn_sync;
    logic [14:0] strap_m;
    logic [14:0] strap_s;
    logic [26:0] din_m;
    logic [26:0] din_s;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            lclk_sync <= 2'h0;
            lclk_d    <= 1'b0;
            pdn_sync  <= 2'h0;
        end else begin
            lclk_sync <= {lclk_sync[0], link_clk};
            lclk_d    <= lclk_sync[1];
            pdn_sync  <= {pdn_sync[0], power_down_n};
        end
    end

    // straps and data carry no reset; they only pass through
    always_ff @(posedge clk) begin
        strap_m <= strap_in;
        strap_s <= strap_m;
        din_m   <= {slow_signal_in, data_in};
        din_s   <= din_m;
    end

    wire link_lvl  = lclk_sync[1];
    wire link_edge = lclk_sync[1] ^ lclk_d;
    wire link_rise = lclk_sync[1] & ~lclk_d;
    wire pdn_n     = pdn_sync[1];

    // ========
    // stream monitor: no link edge for too long means no embedded clock
    logic [7:0] stop_cnt;
    wire        stream_absent = (stop_cnt >= 8'(`DSR_STOP_CYC));

    always_ff @(posedge clk) begin
        if (sys_rst || link_edge) begin
            stop_cnt <= 8'h00;
        end else if (!stream_absent) begin
            stop_cnt <= stop_cnt + 8'h01;
        end
    end

    // ========
    // link state machine
    dsr_state_t state;
    dsr_state_t next_state;
    logic [4:0] lock_cnt;
    wire        lock_done = link_rise && (lock_cnt == 5'(`DSR_LOCK_EDGES - 1));

    always_comb begin
        next_state = state;
        case (state)
            DSR_PWR_DOWN: begin
                next_state = DSR_ACQUIRE;                          // R11
            end
            DSR_ACQUIRE: begin
                if (stream_absent) begin
                    next_state = DSR_SLEEP;
                end else if (lock_done) begin
                    next_state = DSR_LOCKED;                       // R12
                end
            end
            DSR_LOCKED: begin
                if (stream_absent) begin
                    next_state = DSR_SLEEP;                        // R9 R10 R13
                end
            end
            DSR_SLEEP: begin
                if (link_edge) begin
                    next_state = DSR_ACQUIRE;                      // R9 R10
                end
            end
            default: begin
                next_state = DSR_PWR_DOWN;
            end
        endcase
        if (!pdn_n) begin
            next_state = DSR_PWR_DOWN;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state <= DSR_PWR_DOWN;
        end else begin
            state <= next_state;
        end
    end

    // lock needs an unbroken run of link edges while acquiring
    always_ff @(posedge clk) begin
        if (sys_rst || state != DSR_ACQUIRE) begin
            lock_cnt <= 5'h00;
        end else if (link_rise) begin
            lock_cnt <= lock_cnt + 5'h01;
        end
    end

    wire in_pd     = (state == DSR_PWR_DOWN);
    wire is_locked = (state == DSR_LOCKED);

    // ========
    // register bus: one wait cycle, then the answer
    logic                 wait_q;
    logic [`DSR_CFG_W-1:0] cfg;
    logic                 ovr;
    logic [2:0]           irq_st;
    logic [2:0]           irq_mask;

    wire req      = avs_read || avs_write;
    wire accept   = req && !wait_q;
    wire wr_ok    = avs_write && !wait_q;
    wire sel_cfg  = (avs_address == `DSR_ADDR_CONFIG);
    wire sel_stat = (avs_address == `DSR_ADDR_STATUS);
    wire sel_ist  = (avs_address == `DSR_ADDR_IRQ_STAT);
    wire sel_imk  = (avs_address == `DSR_ADDR_IRQ_MASK);
    wire rd_clear = avs_read && !wait_q && sel_ist;

    // effective settings: straps until software writes the config
    wire [`DSR_CFG_W-1:0] eff = ovr ? cfg : strap_s;                // R19
    wire        idle_drive = eff[`DSR_F_IDLE_SEL];
    wire        fb_en      = (eff[`DSR_F_FB_FREQ] != 3'h0);

    logic cur_osc;
    wire [31:0] status_word = {26'h000_0000, cur_osc, stream_absent,
                               lock_out, ovr, state};
    wire [31:0] rd_mux = sel_cfg  ? {17'h0_0000, cfg} :
                         sel_stat ? status_word :
                         sel_ist  ? {29'h0000_0000, irq_st} :
                         sel_imk  ? {29'h0000_0000, irq_mask} :
                         32'h0000_0000;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            wait_q       <= 1'b1;
            avs_readdata <= 32'h0000_0000;
        end else begin
            wait_q <= !(req && wait_q);
            if (req && wait_q) begin
                avs_readdata <= rd_mux;
            end
        end
    end

    assign avs_waitrequest = wait_q;

    // power down wipes the control registers; sleep keeps them
    always_ff @(posedge clk) begin
        if (sys_rst || in_pd) begin                                // R8 R10
            cfg      <= `DSR_CFG_RESET;
            ovr      <= 1'b0;
            irq_mask <= `DSR_MASK_RESET;
        end else if (wr_ok && sel_cfg) begin
            cfg <= avs_writedata[`DSR_CFG_W-1:0];
            ovr <= 1'b1;                                           // R19
        end else if (wr_ok && sel_imk) begin
            irq_mask <= avs_writedata[2:0];
        end
    end

    // ========
    // interrupts: sticky, read clears, a new event beats the clear
    wire ev_lock = (state == DSR_ACQUIRE) && (next_state == DSR_LOCKED);
    wire ev_loss = is_locked && (next_state != DSR_LOCKED);
    wire ev_stop = (state != DSR_SLEEP) && (next_state == DSR_SLEEP);
    wire [2:0] ev = {ev_stop, ev_loss, ev_lock};
    wire [2:0] next_irq_st = (irq_st & {3{~rd_clear}}) | ev;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            irq_st <= 3'h0;
            irq    <= 1'b0;
        end else begin
            irq_st <= next_irq_st;
            irq    <= |(next_irq_st & irq_mask);
        end
    end

    // ========
    // analog control outputs
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            receiver_boost_enable  <= 1'b0;
            receiver_boost_level   <= 3'h0;
            clock_edge_rate_select <= 1'b0;
            data_edge_rate_select  <= 1'b0;
        end else begin
            receiver_boost_enable  <= eff[`DSR_F_BOOST_EN];            // R1
            receiver_boost_level   <= eff[`DSR_F_BOOST_EN] ?
                                      eff[`DSR_F_BOOST_LVL] : 3'h0;    // R2
            clock_edge_rate_select <= eff[`DSR_F_CLK_EDGE];            // R3
            data_edge_rate_select  <= eff[`DSR_F_DATA_EDGE];           // R3
        end
    end

    // spread only while recovered clock and data actually run;
    // the table has no guard for a fast link, software must zero it (R5)
    dsr_spread u_spread (
        .clk           (clk),
        .sys_rst       (sys_rst),
        .step          (link_rise),
        .enable        (is_locked),
        .code          (eff[`DSR_F_SPREAD]),
        .low_band      (eff[`DSR_F_LOW_BAND]),
        .spread_active (spread_active),                             // R4
        .spread_depth  (spread_depth),
        .spread_dir    (spread_dir)
    );

    // ========
    // fallback oscillator: half period scales with the select code
    logic [5:0] osc_cnt;
    logic       osc_lvl;
    wire  [5:0] osc_half = 6'(`DSR_OSC_HALF_CYC) * {3'h0, eff[`DSR_F_FB_FREQ]};

    always_ff @(posedge clk) begin
        if (sys_rst || !fb_en) begin
            osc_cnt <= 6'h00;
            osc_lvl <= 1'b0;
        end else if (osc_cnt >= osc_half - 6'h01) begin
            osc_cnt <= 6'h00;
            osc_lvl <= ~osc_lvl;
        end else begin
            osc_cnt <= osc_cnt + 6'h01;
        end
    end

    // ========
    // clock output source: changeover waits until the new source
    // matches the present level, so the pin never sees a runt pulse
    logic src_rec;
    wire want_osc = fb_en && !is_locked && !in_pd;                 // R15 R18
    wire tgt_lvl  = want_osc ? osc_lvl : (is_locked ? link_lvl : 1'b0);
    wire changing = (want_osc != cur_osc) ||
                    (!want_osc && is_locked != src_rec);
    wire next_clk = changing ? recovered_clock_out : tgt_lvl;        // R14

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            cur_osc             <= 1'b0;
            src_rec             <= 1'b0;
            recovered_clock_out <= 1'b0;
        end else begin
            if (changing && tgt_lvl == recovered_clock_out) begin  // R14
                cur_osc <= want_osc;
                src_rec <= !want_osc && is_locked;
            end
            recovered_clock_out <= next_clk;
        end
    end

    // ========
    // output drive and levels
    wire idle_float = !idle_drive;                                 // R17
    wire osc_clk_on = cur_osc || want_osc;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            recovered_clock_oe_n <= 1'b1;
            data_oe_n            <= 1'b1;
            lock_oe_n            <= 1'b1;
            lock_out             <= 1'b0;
            pass_oe_n            <= 1'b1;
            pass_out             <= 1'b0;
        end else if (in_pd) begin
            recovered_clock_oe_n <= idle_float;                    // R16 R17
            data_oe_n            <= idle_float;                    // R16 R17
            lock_oe_n            <= idle_float;                    // R17
            lock_out             <= 1'b0;
            pass_oe_n            <= idle_float;
            pass_out             <= idle_drive;
        end else if (is_locked) begin
            recovered_clock_oe_n <= 1'b0;
            data_oe_n            <= 1'b0;
            lock_oe_n            <= 1'b0;
            lock_out             <= 1'b1;                          // R12
            pass_oe_n            <= 1'b0;
            pass_out             <= 1'b1;
        end else begin
            recovered_clock_oe_n <= idle_float && !osc_clk_on;     // R13 R15
            data_oe_n            <= idle_float && !fb_en;          // R13 R18
            lock_oe_n            <= 1'b0;                          // R11
            lock_out             <= 1'b0;                          // R11 R13 R18
            pass_oe_n            <= 1'b0;
            pass_out             <= 1'b1;                          // R18
        end
    end

    // data follow the recovered clock only while locked
    always_ff @(posedge clk) begin
        if (sys_rst || !is_locked) begin
            data_out        <= 24'h00_0000;                        // R13 R18
            slow_signal_out <= 3'h0;
        end else if (link_rise) begin
            data_out        <= din_s[23:0];
            slow_signal_out <= din_s[26:24];
        end
    end

endmodule : dsr_lock_ctrl

/* File: sim/dsr_link_src.sv */
// dsr_link_src.sv - far-side model: link clock and recovered data
// assumes: run is driven by the bench in the clk domain
`timescale 1ns/100ps

module dsr_link_src (
    input  wire logic        run,
    output logic             link_clk,
    output logic [23:0]      data_in,
    output logic [2:0]       slow_signal_in
);
    // ========
    // 12.5 MHz link, stands low while stopped
    initial begin
        link_clk = 1'b0;
        data_in = 24'h00_0001;
        slow_signal_in = 3'h0;
        #3;
        forever begin
            #40;
            if (run || link_clk)
                link_clk = ~link_clk;
            if (run && !link_clk) begin
                data_in = {data_in[22:0], ~data_in[23]};
                slow_signal_in = slow_signal_in + 3'h1;
            end else if (!run) begin
                // stopped stream: lines keep moving so stale data cannot pass
                data_in = ~data_in;
            end
        end
    end
endmodule : dsr_link_src

/* File: sim/dsr_lock_ctrl_sva.sv */
// dsr_lock_ctrl_sva.sv - checker bound to the lock-control top
// assumes: single clk domain, sys_rst synchronous active high
`timescale 1ns/100ps

module dsr_lock_ctrl_sva (
    input wire logic        clk,
    input wire logic        sys_rst,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic        avs_waitrequest,
    input wire logic        irq,
    input wire logic        link_clk,
    input wire logic        power_down_n,
    input wire logic        receiver_boost_enable,
    input wire logic [2:0]  receiver_boost_level,
    input wire logic        spread_active,
    input wire logic        recovered_clock_out,
    input wire logic [23:0] data_out,
    input wire logic [2:0]  slow_signal_out,
    input wire logic        data_oe_n,
    input wire logic        lock_out,
    input wire logic        lock_oe_n
);
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);

    // ========
    // raw link rises since lock dropped, cycles since last link edge
    logic       link_q;
    logic [4:0] rise_cnt;
    logic [7:0] idle_cnt;
    always_ff @(posedge clk) begin
        link_q <= link_clk;
        if (sys_rst || lock_out || !power_down_n)
            rise_cnt <= 5'h00;
        else if (link_clk && !link_q && rise_cnt != 5'h1f)
            rise_cnt <= rise_cnt + 5'h01;
        if (sys_rst || link_clk != link_q)
            idle_cnt <= 8'h00;
        else if (idle_cnt != 8'hff)
            idle_cnt <= idle_cnt + 8'h01;
    end

    // ========
    // assertions
    a_boost_off: assert property (!receiver_boost_enable |-> receiver_boost_level == 3'h0)
        else $error("boost level set while boost disabled");
    a_lock_count: assert property ($rose(lock_out) |-> rise_cnt >= 5'h10)
        else $error("lock raised before sixteen link rises");
    a_loss_drop: assert property (idle_cnt > 8'h3c |-> !lock_out)
        else $error("lock held with no link edges");
    a_idle_low: assert property (!data_oe_n && !lock_out && !$past(lock_out)
        |-> data_out == 24'h00_0000 && slow_signal_out == 3'h0)
        else $error("driven outputs not low while unlocked");
    a_pd_quiet: assert property (!power_down_n [*8] |-> !lock_out && !spread_active)
        else $error("lock or spread active in power down");
    a_lock_drive: assert property (power_down_n [*8] |-> !lock_oe_n)
        else $error("lock not driven after power up");
    a_clk_smooth: assert property ($changed(recovered_clock_out)
        |=> $stable(recovered_clock_out) [*2])
        else $error("clock output glitch");
    a_bus_answer: assert property ((avs_read || avs_write) && avs_waitrequest
        |=> !avs_waitrequest ##1 avs_waitrequest)
        else $error("bus answer not a single cycle");

    c_lock: cover property ($rose(lock_out));
    c_loss: cover property ($fell(lock_out));
    c_spread: cover property (spread_active);
    c_irq: cover property ($rose(irq));
endmodule : dsr_lock_ctrl_sva

bind dsr_lock_ctrl dsr_lock_ctrl_sva u_sva (.*);

/* File: sim/dsr_lock_ctrl_test.sv */
// dsr_lock_ctrl_test.sv - self-checking bench for the lock-control block
// assumes: dsr_link_src as far side, straps held constant
`timescale 1ns/100ps
`include "dsr_defs.svh"

module dsr_lock_ctrl_test import dsr_pkg::*;;
    logic        clk, sys_rst, avs_read, avs_write, avs_waitrequest, irq, run;
    logic [4:0]  avs_address;
    logic [31:0] avs_writedata, avs_readdata, q;
    logic        link_clk, power_down_n, receiver_boost_enable, clock_edge_rate_select;
    logic        data_edge_rate_select, spread_active, spread_dir, recovered_clock_out;
    logic        recovered_clock_oe_n, data_oe_n, lock_out, lock_oe_n, pass_out, pass_oe_n;
    logic [23:0] data_in, data_out;
    logic [2:0]  slow_signal_in, slow_signal_out, receiver_boost_level;
    logic [14:0] strap_in;
    logic [1:0]  spread_depth;
    int          fail_count, n_compared, n;
    logic [14:0] cfg_row [7] = '{15'h0000, 15'h000e, 15'h0001, 15'h000f, 15'h0010,
                                 15'h0020, 15'h0035};
    logic [5:0]  exp_row [7] = '{6'h00, 6'h00, 6'h01, 6'h0f, 6'h10, 6'h20, 6'h35};

    dsr_link_src u_src (.*);
    dsr_lock_ctrl uut (.*);

    always #4 clk = ~clk;

    // ========
    // tasks
    task automatic test_done;
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : test_done

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask : chk

    task automatic chk_in(input int got, input int lo, input int hi, input string m);
        n_compared++;
        if (got < lo || got > hi) begin
            fail_count++;
            $display("CHECK FAILED %0t %s got %0d", $time, m, got);
        end
    endtask : chk_in

    task automatic cyc(input int k);
        repeat (k) @(posedge clk);
    endtask : cyc

    task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d,
                       output logic [31:0] rd);
        int k;
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (avs_waitrequest !== 1'b0 && k < 50);
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge clk);
        if (k == 50) begin
            fail_count++;
            test_done();
        end
    endtask : bus

    task automatic wait_lock(input logic v);
        n = 0;
        while (lock_out !== v && n < 2000) begin
            @(posedge clk);
            n++;
        end
        chk(lock_out, v, "lock wait");
    endtask : wait_lock

    // cycles between two spread direction flips, after one flip to align
    task automatic gap(input logic [31:0] cfg, input int exp);
        logic v;
        bus(1, `DSR_ADDR_CONFIG, cfg, q);
        for (int j = 0; j < 2; j++) begin
            v = spread_dir;
            n = 0;
            while (spread_dir === v && n < 5000) begin
                @(posedge clk);
                n++;
            end
        end
        chk_in(n, exp - 3, exp + 3, "spread period");
    endtask : gap

    // ========
    // sequence
    initial begin
        clk = 0; sys_rst = 1; avs_read = 0; avs_write = 0; avs_address = 5'h00;
        avs_writedata = 32'h0000_0000; power_down_n = 0; run = 0; strap_in = 15'h0003;
        fail_count = 0; n_compared = 0;
        repeat (2) @(posedge clk);
        sys_rst <= 0;
        @(posedge clk);
        chk({avs_waitrequest, lock_oe_n, data_oe_n}, 7, "reset state");
        bus(1, `DSR_ADDR_CONFIG, 32'h0000_0001, q);
        bus(0, `DSR_ADDR_CONFIG, 0, q);
        chk(q, 0, "config held in pd");
        power_down_n <= 1;
        cyc(10);
        chk({lock_oe_n, lock_out}, 0, "lock low after pd");
        chk({receiver_boost_level, receiver_boost_enable}, 3, "strap governs");
        bus(1, `DSR_ADDR_IRQ_MASK, 7, q);
        run <= 1;
        wait_lock(1);
        chk({data_oe_n, recovered_clock_oe_n}, 0, "outputs driven");
        @(posedge link_clk);
        q = {8'h00, data_in};
        @(negedge link_clk);
        @(posedge clk);
        chk({8'h00, data_out}, q, "data follows");
        chk(irq, 1, "irq on lock");
        bus(0, `DSR_ADDR_IRQ_STAT, 0, q);
        chk(q, 1, "lock event");
        cyc(2);
        chk(irq, 0, "irq cleared");
        for (int i = 0; i < 7; i++) begin
            bus(1, `DSR_ADDR_CONFIG, {17'h0_0000, cfg_row[i]}, q);
            cyc(4);
            chk({data_edge_rate_select, clock_edge_rate_select, receiver_boost_level,
                 receiver_boost_enable}, exp_row[i], "edge and boost");
        end
        for (int c = 0; c < 32; c++) begin
            bus(1, `DSR_ADDR_CONFIG, 32'((c & 16) << 6 | (c & 15) << 6), q);
            cyc(4);
            chk(spread_active, (c & 15) != 0, "spread on");
            if ((c & 15) != 0)
                chk(spread_depth, ((c & 15) - 1) & 3, "spread depth");
        end
        gap(32'h0000_0340, `DSR_DIV_HI_3 * 5);
        gap(32'h0000_0740, `DSR_DIV_LO_3 * 5);
        bus(1, `DSR_ADDR_IRQ_MASK, 0, q);
        bus(1, `DSR_ADDR_CONFIG, 32'h0000_1800, q);
        run <= 0;
        wait_lock(0);
        cyc(20);
        chk({lock_out, data_oe_n, data_out, slow_signal_out}, 0, "idle low");
        chk({pass_out, irq}, 2, "pass high, irq masked");
        n = 0;
        q[0] = recovered_clock_out;
        repeat (40) begin
            @(posedge clk);
            if (recovered_clock_out !== q[0])
                n++;
            q[0] = recovered_clock_out;
        end
        chk_in(n, 6, 9, "oscillator toggles");
        bus(0, `DSR_ADDR_STATUS, 0, q);
        chk(q & 3, 3, "sleep state");
        bus(0, `DSR_ADDR_CONFIG, 0, q);
        chk(q, 32'h0000_1800, "config retained");
        bus(1, `DSR_ADDR_IRQ_MASK, 7, q);
        cyc(3);
        chk(irq, 1, "irq unmasked");
        bus(0, `DSR_ADDR_IRQ_STAT, 0, q);
        chk(q, 6, "loss and stop events");
        run <= 1;
        wait_lock(1);
        bus(0, 5'h10, 0, q);
        chk(q, 0, "unmapped read");
        power_down_n <= 0;
        cyc(10);
        chk({data_oe_n, lock_oe_n}, 3, "float in pd");
        bus(0, `DSR_ADDR_CONFIG, 0, q);
        chk(q, 0, "config reset by pd");
        test_done();
    end
endmodule : dsr_lock_ctrl_test
